// File: tb/nand_status_and_protect_asserts.sv
// Port checker for the status and protection block
`timescale 1ns/1ps
`default_nettype none
module nand_status_and_protect_asserts
   import nand_status_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic buf_mode,
   input wire logic op_done,
   input wire logic op_start,
   input var op_kind_t op_kind,
   input wire logic [15:0] op_page,
   input wire logic dev_reset,
   input wire logic [7:0] nand_status_flags,
   input wire logic block_protect_bit3,
   input wire logic block_protect_bit2,
   input wire logic block_protect_bit1,
   input wire logic block_protect_bit0,
   input wire logic top_bottom_select
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Protected span and target block of an array request
   logic [3:0] bp_code;
   logic [10:0] span;
   logic [10:0] blk;
   logic arr_op;
   logic busy_op;
   assign bp_code = {block_protect_bit3, block_protect_bit2,
      block_protect_bit1, block_protect_bit0};
   assign span = 11'h1 << bp_code;
   assign blk = {1'b0, op_page[15:6]};
   assign arr_op = op_start && (op_kind == OPK_PROGRAM || op_kind == OPK_ERASE);
   assign busy_op = arr_op || (op_start && op_kind == OPK_PAGE_READ);
   a_reserved_bits_zero: assert property (nand_status_flags[7:6] == 2'h0)
      else $error("reserved status bits set");
   a_busy_on_start: assert property (busy_op |-> ##[1:2] nand_status_flags[0])
      else $error("busy not raised");
   a_latch_cleared: assert property (busy_op |-> ##[1:2] !nand_status_flags[1])
      else $error("latch not cleared");
   a_range_protect: assert property (arr_op && bp_code inside {[4'h1:4'h9]} |->
      (top_bottom_select ? blk >= span : blk < 11'h400 - span))
      else $error("protected block started");
   a_full_protect: assert property (arr_op |->
      !(block_protect_bit3 && (block_protect_bit2 || block_protect_bit1)))
      else $error("fully protected array started");
   a_reset_clears: assert property (dev_reset |->
      ##[1:2] nand_status_flags[5:2] == 4'h0)
      else $error("reset left flags set");
   a_done_clears_busy: assert property (op_done |-> ##[1:2] !nand_status_flags[0])
      else $error("busy stuck after done");
   a_buffer_no_multi: assert property (buf_mode [*6] ##0 nand_status_flags[5:4] != 2'h3
      |=> nand_status_flags[5:4] != 2'h3)
      else $error("multi fail code in buffer mode");
endmodule // nand_status_and_protect_asserts
bind nand_status_and_protect nand_status_and_protect_asserts i_chk (.*);
`default_nettype wire

// File: tb/nand_status_and_protect_bench.sv
// Self-checking bench for the status and protection block
`timescale 1ns/1ps
`default_nettype none
module nand_status_and_protect_bench
   import nand_status_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic spi_cs_n, spi_sck, spi_di, spi_do, spi_do_oe, op_start, dev_reset;
   logic buf_mode = 1'b0;
   logic ecc_enable = 1'b1;
   logic op_done = 1'b0;
   logic op_fail = 1'b0;
   logic page_ecc_valid = 1'b0;
   logic [1:0] page_ecc_result = 2'h0;
   logic [15:0] page_ecc_page = 16'h0;
   op_kind_t op_kind, last_kind;
   logic [15:0] op_page, last_page, rx;
   logic [7:0] nand_status_flags;
   logic block_protect_bit3, block_protect_bit2, block_protect_bit1, block_protect_bit0;
   logic top_bottom_select;
   int failures = 0;
   int samples_checked = 0;
   int starts = 0;
   int n;
   logic [7:0] opc [2] = '{8'h10, 8'hd8};
   logic [7:0] fl [2] = '{8'h08, 8'h04};
   op_kind_t kd [2] = '{OPK_PROGRAM, OPK_ERASE};
   logic [7:0] pv [2] = '{8'h50, 8'h04};
   logic [1:0] res [3] = '{2'h1, 2'h2, 2'h2};
   logic [15:0] pg [3] = '{16'h0010, 16'h0123, 16'h0456};
   nand_status_and_protect i_dut (.*);
   spi_host_model i_host (.*);
   always #5 sys_clk = ~sys_clk;
   // Engine request monitor
   always @(posedge sys_clk) begin
      if (op_start === 1'b1) begin
         starts++;
         last_kind = op_kind;
         last_page = op_page;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Engine finish, optionally reporting a failed operation first
   task automatic done(input logic bad);
      op_fail <= bad;
      @(posedge sys_clk);
      op_fail <= 1'b0;
      op_done <= 1'b1;
      @(posedge sys_clk);
      op_done <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic ecc(input logic [1:0] r, input logic [15:0] p);
      page_ecc_valid <= 1'b1;
      page_ecc_result <= r;
      page_ecc_page <= p;
      @(posedge sys_clk);
      page_ecc_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence of link frames and engine events
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(nand_status_flags, 8'h01);
      i_host.frame(1, 32'h06000000, rx);
      i_host.frame(3, 32'h0fc00000, rx);
      chk(rx[7:0], 8'h01);
      // Identification is still served while busy
      i_host.frame(4, 32'h9f000000, rx);
      chk(rx, 16'h5a12);
      done(1'b0);
      chk(nand_status_flags, 8'h00);
      i_host.frame(1, 32'h06000000, rx);
      i_host.frame(3, 32'h0fc00000, rx);
      chk(rx[7:0], 8'h02);
      i_host.frame(1, 32'h04000000, rx);
      chk(nand_status_flags, 8'h00);
      i_host.frame(3, 32'h1fa08b00, rx);
      i_host.frame(3, 32'h0fa00000, rx);
      chk(rx[7:0], 8'h08);
      chk({block_protect_bit3, block_protect_bit2, block_protect_bit1, block_protect_bit0,
         top_bottom_select}, 5'h02);
      // Protected and edge-of-range targets for program and erase
      for (int k = 0; k < 2; k++) begin
         n = starts;
         i_host.frame(1, 32'h06000000, rx);
         i_host.frame(4, {opc[k], 24'h00ff80}, rx);
         chk(starts, n);
         chk(nand_status_flags, fl[k]);
         i_host.frame(1, 32'h06000000, rx);
         i_host.frame(4, {opc[k], 24'h00ff7f}, rx);
         chk({last_kind, last_page}, {kd[k], 16'hff7f});
         chk(nand_status_flags, 8'h01);
         done(1'b1);
         chk(nand_status_flags, fl[k]);
      end
      // Whole-array code refuses block 0, code 0000 frees it
      for (int j = 0; j < 2; j++) begin
         n = starts;
         i_host.frame(3, {16'h1fa0, pv[j], 8'h00}, rx);
         i_host.frame(1, 32'h06000000, rx);
         i_host.frame(4, 32'h10000000, rx);
         chk(starts - n, j);
         if (j == 1)
            done(1'b1);
      end
      // Continuous read accumulation and last failing page
      i_host.frame(4, 32'h13000040, rx);
      done(1'b0);
      for (int e = 0; e < 3; e++) begin
         ecc(res[e], pg[e]);
         chk(nand_status_flags[5:4], e + 1);
      end
      i_host.frame(4, 32'ha9000000, rx);
      chk(rx, 16'h0456);
      chk(spi_do_oe, 1'b0);
      buf_mode <= 1'b1;
      i_host.frame(4, 32'h13000080, rx);
      done(1'b0);
      chk(nand_status_flags[5:4], 2'h0);
      ecc(2'h2, 16'h0081);
      ecc(2'h2, 16'h0082);
      chk(nand_status_flags[5:4], 2'h2);
      // Continuous read end clears the code and raises busy
      buf_mode <= 1'b0;
      i_host.frame(2, 32'h03000000, rx);
      chk(nand_status_flags, 8'h09);
      done(1'b0);
      ecc(2'h1, 16'h0090);
      i_host.frame(1, 32'hff000000, rx);
      chk(nand_status_flags[5:2], 4'h0);
      stop_test();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #300000;
      failures++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule // nand_status_and_protect_bench
`default_nettype wire

// File: tb/spi_host_model.sv
// Link host model that clocks whole frames into the status block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic sys_clk,
   input wire logic spi_do,
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_di
);
   // Idle link: deselected, clock parked low between frames
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_di = 1'b0;
   end
   // Half of the 80 ns link clock period
   task automatic half();
      repeat (4) @(posedge sys_clk);
   endtask
   // One byte, MSB first, mode 0; each returned bit taken at a rising sck
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_di <= tx[i];
         half();
         spi_sck <= 1'b1;
         rx = {rx[6:0], spi_do};
         half();
         spi_sck <= 1'b0;
      end
   endtask
   // Frame of n left-aligned bytes; the last two returned bytes come back
   task automatic frame(input int n, input logic [31:0] tx, output logic [15:0] rx);
      logic [7:0] b;
      spi_cs_n <= 1'b0;
      half();
      for (int k = 0; k < n; k++) begin
         xfer(tx[31-8*k -: 8], b);
         rx = {rx[7:0], b};
      end
      half();
      spi_cs_n <= 1'b1;
      repeat (16) @(posedge sys_clk);
   endtask
endmodule // spi_host_model
`default_nettype wire

// File: verilog/nand_status_and_protect.sv
// Status flags, ECC accumulation and block protection behind the serial link
`timescale 1ns/1ps
`default_nettype none
`include "nand_status_map.svh"
module nand_status_and_protect
   import nand_status_pkg::*;
#(
   parameter logic [7:0] PROT_RESET = 8'h00,
   parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
   parameter logic [15:0] DEV_ID = 16'h1234 // Arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_di,
   output logic spi_do,
   output logic spi_do_oe,
   input wire logic buf_mode,
   input wire logic ecc_enable,
   input wire logic op_done,
   input wire logic op_fail,
   input wire logic page_ecc_valid,
   input wire logic [1:0] page_ecc_result,
   input wire logic [15:0] page_ecc_page,
   output logic op_start,
   output var op_kind_t op_kind,
   output logic [15:0] op_page,
   output logic dev_reset,
   output logic [7:0] nand_status_flags,
   output logic block_protect_bit3,
   output logic block_protect_bit2,
   output logic block_protect_bit1,
   output logic block_protect_bit0,
   output logic top_bottom_select
);
   // Synchronised link pins
   logic cs_s;
   logic sck_s;
   logic di_s;

   // Link framing state
   logic [7:0] rx_q, rx_d;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [3:0] byte_cnt_q, byte_cnt_d;
   logic [7:0] opcode_q, opcode_d;
   logic [7:0] sr_addr_q, sr_addr_d;
   logic [7:0] wr_data_q, wr_data_d;
   logic [15:0] page_address_q, page_address_d;
   logic [7:0] tx_q, tx_d;
   logic do_q, do_d;
   logic oe_q, oe_d;
   logic ignore_q, ignore_d;
   logic sck_last_q, sck_last_d;
   logic cs_last_q, cs_last_d;

   // Flags and protection state
   logic busy_q, busy_d;
   logic write_enable_latch_q, write_enable_latch_d;
   logic pfail_q, pfail_d;
   logic efail_q, efail_d;
   logic [1:0] ecc_q, ecc_d;
   logic [7:0] prot_q, prot_d;
   logic [15:0] fail_page_q, fail_page_d;
   op_kind_t run_kind_q, run_kind_d;
   logic op_start_q, op_start_d;
   op_kind_t op_kind_q, op_kind_d;
   logic [15:0] op_page_q, op_page_d;
   logic dev_reset_q, dev_reset_d;
   logic [7:0] status_q, status_d;
   logic [7:0] status_now;

   // Block lies inside the protected range
   function automatic logic blk_protected(input logic [3:0] bp, input logic tb,
                                          input logic [9:0] blk);
      logic [10:0] span;
      span = 11'h1 << bp;
      if (bp == 4'h0) begin
         return 1'b0;
      end else if (bp[3] && (bp[2] || bp[1])) begin
         return 1'b1;
      end else if (tb) begin
         return {1'b0, blk} < span;
      end else begin
         return {1'b0, blk} >= (`BLK_COUNT - span);
      end
   endfunction

   // Worst outcome so far merged with one page result
   function automatic logic [1:0] ecc_merge(input logic [1:0] cur, input logic [1:0] res,
                                            input logic cont);
      logic [1:0] nxt;
      nxt = cur;
      case (res)
         `PG_CORR: begin
            if (cur == `ECC_NONE) begin
               nxt = `ECC_CORR;
            end
         end
         `PG_FAIL: begin
            if ((cur == `ECC_ONE_FAIL || cur == `ECC_MULTI_FAIL) && cont) begin
               nxt = `ECC_MULTI_FAIL;
            end else if (cur != `ECC_MULTI_FAIL) begin
               nxt = `ECC_ONE_FAIL;
            end
         end
         default: nxt = cur; // Clean page leaves code as is
      endcase
      return nxt;
   endfunction

   // Any array read opcode that streams data
   function automatic logic is_read_op(input logic [7:0] op);
      case (op)
         8'h03, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c,
         8'hbb, 8'hbc, 8'heb, 8'hec: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Register read selected by the address byte
   function automatic logic [7:0] sr_read(input logic [7:0] addr, input logic [7:0] prot,
                                          input logic [7:0] stat);
      if (addr[7:4] == `SEL_PROT) begin
         return prot;
      end else if (addr[7:4] == `SEL_STATUS) begin
         return stat;
      end else begin
         return 8'h00;
      end
   endfunction

   pin_sync3 #(
      .W(3),
      .RST_VAL(3'h4)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({spi_cs_n, spi_sck, spi_di}),
      .q({cs_s, sck_s, di_s})
   );

   // Live status image, reserved bits read zero
   always_comb begin
      status_now = 8'h00;
      status_now[`ST_BUSY] = busy_q;
      status_now[`ST_WEL] = write_enable_latch_q;
      status_now[`ST_EFAIL] = efail_q;
      status_now[`ST_PFAIL] = pfail_q;
      status_now[`ST_ECC_HI:`ST_ECC_LO] = ecc_q;
   end

   // Next-state logic for framing, flags and engine requests
   always_comb begin
      logic [7:0] rx_byte;
      logic [3:0] nb;
      logic [7:0] txb;
      logic txv;
      logic whole;
      logic cs_rise;
      logic cs_fall;
      logic sck_rise;
      op_kind_t k;
      rx_byte = {rx_q[6:0], di_s};
      nb = (byte_cnt_q == 4'hf) ? byte_cnt_q : byte_cnt_q + 4'h1;
      txb = 8'h00;
      txv = 1'b0;
      whole = (bit_cnt_q == 3'h0);
      cs_rise = cs_s && !cs_last_q;
      cs_fall = !cs_s && cs_last_q;
      sck_rise = sck_s && !sck_last_q && !cs_s;
      k = OPK_NONE;
      rx_d = rx_q;
      bit_cnt_d = bit_cnt_q;
      byte_cnt_d = byte_cnt_q;
      opcode_d = opcode_q;
      sr_addr_d = sr_addr_q;
      wr_data_d = wr_data_q;
      page_address_d = page_address_q;
      tx_d = tx_q;
      do_d = do_q;
      oe_d = oe_q;
      ignore_d = ignore_q;
      busy_d = busy_q;
      write_enable_latch_d = write_enable_latch_q;
      pfail_d = pfail_q;
      efail_d = efail_q;
      ecc_d = ecc_q;
      prot_d = prot_q;
      fail_page_d = fail_page_q;
      run_kind_d = run_kind_q;
      op_start_d = 1'b0;
      op_kind_d = op_kind_q;
      op_page_d = op_page_q;
      dev_reset_d = 1'b0;
      status_d = status_now;
      sck_last_d = sck_s;
      cs_last_d = cs_s;

      // Frame start
      if (cs_fall) begin
         bit_cnt_d = 3'h0;
         byte_cnt_d = 4'h0;
         ignore_d = 1'b0;
         oe_d = 1'b0;
      end

      // Engine finished; placed before commits so a new start wins
      if (op_done) begin
         busy_d = 1'b0;
         run_kind_d = OPK_NONE;
      end

      // Bit taken on a rising link clock; next output bit launched at once
      if (sck_rise) begin
         rx_d = rx_byte;
         bit_cnt_d = bit_cnt_q + 3'h1;
         if (oe_q) begin
            do_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
         end
         if (bit_cnt_q == 3'h7) begin
            byte_cnt_d = nb;
            case (byte_cnt_q)
               4'h0: begin
                  opcode_d = rx_byte;
                  if (busy_q && rx_byte != `OP_RD_STATUS_A && rx_byte != `OP_RD_STATUS_B
                      && rx_byte != `OP_JEDEC_ID) begin
                     ignore_d = 1'b1;
                  end else if (is_read_op(rx_byte)) begin
                     ecc_d = `ECC_NONE;
                  end
               end
               4'h1: sr_addr_d = rx_byte;
               4'h2: begin
                  wr_data_d = rx_byte;
                  page_address_d[15:8] = rx_byte;
               end
               4'h3: page_address_d[7:0] = rx_byte;
               default: ;
            endcase
            // Select the byte to return next
            if (nb >= 4'h2 && !ignore_q) begin
               case (opcode_q)
                  `OP_RD_STATUS_A, `OP_RD_STATUS_B: begin
                     txv = 1'b1;
                     txb = sr_read((nb == 4'h2) ? rx_byte : sr_addr_q, prot_q, status_now);
                  end
                  `OP_JEDEC_ID: begin
                     txv = (nb <= 4'h4);
                     txb = (nb == 4'h2) ? MFR_ID : ((nb == 4'h3) ? DEV_ID[15:8] : DEV_ID[7:0]);
                  end
                  `OP_FAIL_PAGE: begin
                     txv = (nb <= 4'h3);
                     txb = (nb == 4'h2) ? fail_page_q[15:8] : fail_page_q[7:0];
                  end
                  default: txv = 1'b0;
               endcase
            end
            if (txv) begin
               do_d = txb[7];
               tx_d = {txb[6:0], 1'b0};
               oe_d = 1'b1;
            end else begin
               oe_d = 1'b0;
            end
         end
      end

      // Frame end commits the instruction
      if (cs_rise) begin
         oe_d = 1'b0;
         if (!ignore_q) begin
            case (opcode_q)
               `OP_WR_ENABLE: begin
                  if (whole && byte_cnt_q == `LEN_SINGLE) begin
                     write_enable_latch_d = 1'b1;
                  end
               end
               `OP_WR_DISABLE: begin
                  if (whole && byte_cnt_q == `LEN_SINGLE) begin
                     write_enable_latch_d = 1'b0;
                  end
               end
               `OP_DEV_RESET: begin
                  if (whole && byte_cnt_q == `LEN_SINGLE) begin
                     pfail_d = 1'b0;
                     efail_d = 1'b0;
                     ecc_d = `ECC_NONE;
                     dev_reset_d = 1'b1;
                  end
               end
               `OP_WR_STATUS_A, `OP_WR_STATUS_B: begin
                  if (whole && byte_cnt_q == `LEN_WR_STATUS && sr_addr_q[7:4] == `SEL_PROT) begin
                     prot_d = wr_data_q & `PR_WR_MASK;
                  end
               end
               `OP_PROG_EXEC, `OP_BLK_ERASE: begin
                  if (whole && byte_cnt_q == `LEN_PAGE_CMD) begin
                     pfail_d = 1'b0;
                     efail_d = 1'b0;
                     write_enable_latch_d = 1'b0;
                     if (write_enable_latch_q) begin
                        if (blk_protected(prot_q[`PR_BP_HI:`PR_BP_LO], prot_q[`PR_TB],
                                          page_address_q[`BLK_HI:`BLK_LO])) begin
                           // Refused: flag failure, no engine start
                           if (opcode_q == `OP_PROG_EXEC) begin
                              pfail_d = 1'b1;
                           end else begin
                              efail_d = 1'b1;
                           end
                        end else begin
                           k = (opcode_q == `OP_PROG_EXEC) ? OPK_PROGRAM : OPK_ERASE;
                        end
                     end
                  end
               end
               `OP_PAGE_READ: begin
                  if (whole && byte_cnt_q == `LEN_PAGE_CMD) begin
                     write_enable_latch_d = 1'b0;
                     ecc_d = `ECC_NONE;
                     k = OPK_PAGE_READ;
                  end
               end
               `OP_BLK_SWAP: begin
                  if (whole && byte_cnt_q == `LEN_SWAP) begin
                     k = OPK_SWAP;
                  end
               end
               default: begin
                  if (is_read_op(opcode_q) && !buf_mode) begin
                     k = OPK_CONT_END;
                  end
               end
            endcase
         end
         // Engine start raises busy
         if (k != OPK_NONE) begin
            busy_d = 1'b1;
            op_start_d = 1'b1;
            op_kind_d = k;
            op_page_d = page_address_q;
            run_kind_d = k;
         end
      end

      // Engine failure, after the clears so it survives
      if (op_fail) begin
         if (run_kind_q == OPK_PROGRAM) begin
            pfail_d = 1'b1;
         end else if (run_kind_q == OPK_ERASE) begin
            efail_d = 1'b1;
         end
      end

      // Page results accumulate after any clear
      if (page_ecc_valid && ecc_enable) begin
         ecc_d = ecc_merge(ecc_d, page_ecc_result, !buf_mode);
         if (page_ecc_result == `PG_FAIL && !buf_mode) begin
            fail_page_d = page_ecc_page;
         end
      end
   end

   // State registers; busy set and latch clear at power-up
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 4'h0;
         opcode_q <= 8'h00;
         sr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         page_address_q <= 16'h0000;
         tx_q <= 8'h00;
         do_q <= 1'b0;
         oe_q <= 1'b0;
         ignore_q <= 1'b0;
         sck_last_q <= 1'b0;
         cs_last_q <= 1'b1;
         busy_q <= 1'b1;
         write_enable_latch_q <= 1'b0;
         pfail_q <= 1'b0;
         efail_q <= 1'b0;
         ecc_q <= `ECC_NONE;
         prot_q <= PROT_RESET;
         fail_page_q <= 16'h0000;
         run_kind_q <= OPK_NONE;
         op_start_q <= 1'b0;
         op_kind_q <= OPK_NONE;
         op_page_q <= 16'h0000;
         dev_reset_q <= 1'b0;
         status_q <= 8'h00;
      end else begin
         rx_q <= rx_d;
         bit_cnt_q <= bit_cnt_d;
         byte_cnt_q <= byte_cnt_d;
         opcode_q <= opcode_d;
         sr_addr_q <= sr_addr_d;
         wr_data_q <= wr_data_d;
         page_address_q <= page_address_d;
         tx_q <= tx_d;
         do_q <= do_d;
         oe_q <= oe_d;
         ignore_q <= ignore_d;
         sck_last_q <= sck_last_d;
         cs_last_q <= cs_last_d;
         busy_q <= busy_d;
         write_enable_latch_q <= write_enable_latch_d;
         pfail_q <= pfail_d;
         efail_q <= efail_d;
         ecc_q <= ecc_d;
         prot_q <= prot_d;
         fail_page_q <= fail_page_d;
         run_kind_q <= run_kind_d;
         op_start_q <= op_start_d;
         op_kind_q <= op_kind_d;
         op_page_q <= op_page_d;
         dev_reset_q <= dev_reset_d;
         status_q <= status_d;
      end
   end

   // Outputs straight from registers
   assign spi_do = do_q;
   assign spi_do_oe = oe_q;
   assign op_start = op_start_q;
   assign op_kind = op_kind_q;
   assign op_page = op_page_q;
   assign dev_reset = dev_reset_q;
   assign nand_status_flags = status_q;
   assign block_protect_bit3 = prot_q[`PR_BP_HI];
   assign block_protect_bit2 = prot_q[`PR_BP_HI - 1];
   assign block_protect_bit1 = prot_q[`PR_BP_LO + 1];
   assign block_protect_bit0 = prot_q[`PR_BP_LO];
   assign top_bottom_select = prot_q[`PR_TB];
endmodule // nand_status_and_protect
`default_nettype wire

// File: verilog/nand_status_map.svh
// Offsets, field positions, opcodes and codes of the status and protection block
`ifndef NAND_STATUS_MAP_SVH
`define NAND_STATUS_MAP_SVH

// Instruction opcodes
`define OP_RD_STATUS_A 8'h0f
`define OP_RD_STATUS_B 8'h05
`define OP_WR_STATUS_A 8'h1f
`define OP_WR_STATUS_B 8'h01
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_DEV_RESET 8'hff
`define OP_JEDEC_ID 8'h9f
`define OP_BLK_SWAP 8'ha1
`define OP_FAIL_PAGE 8'ha9
`define OP_BLK_ERASE 8'hd8
`define OP_PROG_EXEC 8'h10
`define OP_PAGE_READ 8'h13

// Frame lengths in whole bytes for committing instructions
`define LEN_SINGLE 4'h1
`define LEN_WR_STATUS 4'h3
`define LEN_PAGE_CMD 4'h4
`define LEN_SWAP 4'h5

// Status register selector (upper nibble of the address byte)
`define SEL_PROT 4'ha
`define SEL_STATUS 4'hc

// Status flag bit positions
`define ST_BUSY 0
`define ST_WEL 1
`define ST_EFAIL 2
`define ST_PFAIL 3
`define ST_ECC_LO 4
`define ST_ECC_HI 5

// Protection register fields
`define PR_BP_HI 6
`define PR_BP_LO 3
`define PR_TB 2
`define PR_WR_MASK 8'h7c

// Page address field that selects the block
`define BLK_HI 15
`define BLK_LO 6
`define BLK_COUNT 11'h400

// Cumulative ECC codes
`define ECC_NONE 2'h0
`define ECC_CORR 2'h1
`define ECC_ONE_FAIL 2'h2
`define ECC_MULTI_FAIL 2'h3

// Per-page result codes from the array engine
`define PG_CLEAN 2'h0
`define PG_CORR 2'h1
`define PG_FAIL 2'h2

`endif

// File: verilog/nand_status_pkg.sv
// Types shared by the status and protection block
package nand_status_pkg;
   // Operation handed to the array engine
   typedef enum logic [2:0] {
      OPK_NONE,
      OPK_PAGE_READ,
      OPK_PROGRAM,
      OPK_ERASE,
      OPK_SWAP,
      OPK_CONT_END
   } op_kind_t;
endpackage

// File: verilog/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_d;

   // A bit changes once stages two and three agree
   always_comb begin
      q_d = q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            q_d[i] = s3_q[i];
         end
      end
   end

   // Chain registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q <= q_d;
      end
   end
endmodule // pin_sync3
`default_nettype wire
